/* File: hdl/pdc_channel_pair.v */
// Peripheral DMA channel pair: one receive and one transmit channel for a
// group of identical peripherals, with chained current/next buffers.
// Assumes an Avalon-MM slave for software, a single-cycle system bus master
// port with grant, and peripherals giving rising-edge requests on the same clock.
`include "pdc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pdc_channel_pair #(
    parameter NPER = 2
) (
    input wire SYS_CLK_I,               // Master clock, 100 MHz
    input wire RESET_N_I,               // Asynchronous reset, active low
    input wire [11:0] AVS_ADDRESS_I,    // Byte address in peripheral map
    input wire AVS_READ_I,              // Read strobe
    input wire AVS_WRITE_I,             // Write strobe
    input wire [31:0] AVS_WRITEDATA_I,  // Write data
    input wire [3:0] AVS_BYTEENABLE_I,  // Byte enables
    output reg [31:0] AVS_READDATA_O,   // Read data
    output wire AVS_WAITREQUEST_O,      // Wait request
    input wire [NPER-1:0] RX_REQ_I,     // Peripheral receive requests
    input wire [NPER-1:0] TX_REQ_I,     // Peripheral transmit requests
    output reg [NPER-1:0] PER_RD_O,     // Peripheral holding read strobe
    output reg [NPER-1:0] PER_WR_O,     // Peripheral transmit write strobe
    input wire [31:0] PER_RDATA_I,      // Peripheral receive holding data
    output reg [31:0] PER_WDATA_O,      // Data to peripheral
    output reg BUS_REQ_O,               // System bus request
    input wire BUS_GNT_I,               // System bus grant
    output reg [31:0] MEM_ADDR_O,       // Memory address
    output reg MEM_RD_O,                // Memory read strobe
    output reg MEM_WR_O,                // Memory write strobe
    output reg [1:0] MEM_SIZE_O,        // Transfer size code
    output reg [31:0] MEM_WDATA_O,      // Memory write data
    input wire [31:0] MEM_RDATA_I,      // Memory read data, same cycle
    output wire RX_END_O,               // Receive buffer end flag
    output wire RX_FULL_O,              // Receive all buffers full flag
    output wire TX_END_O,               // Transmit buffer end flag
    output wire TX_EMPTY_O              // Transmit all buffers empty flag
);

    localparam ST_IDLE = 2'h0;
    localparam ST_REQ = 2'h1;
    localparam ST_RXWR = 2'h2;
    localparam ST_DONE = 2'h3;

    reg [31:0] rx_ptr_reg, rx_nptr_reg, tx_ptr_reg, tx_nptr_reg;
    reg [15:0] rx_cnt_reg, rx_ncnt_reg, tx_cnt_reg, tx_ncnt_reg;
    reg rx_en_reg, tx_en_reg;
    reg rx_end_reg, tx_end_reg;
    reg [1:0] size_reg;
    reg [1:0] state_reg;
    reg dir_tx_reg;
    reg [NPER-1:0] sel_reg;
    reg [31:0] hold_reg;
    reg [NPER-1:0] rx_pend_reg, tx_pend_reg;
    reg [NPER-1:0] rx_prev_reg, tx_prev_reg;

    wire in_map = (AVS_ADDRESS_I[11:8] == 4'h1) &&
        (AVS_ADDRESS_I[7:6] == 2'h0);
    wire wr = AVS_WRITE_I && in_map;
    // Every access answers in the cycle it is raised
    assign AVS_WAITREQUEST_O = 1'b0;

    wire [31:0] wmask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
        {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};

    wire wr_rx_ptr = wr && (AVS_ADDRESS_I == `PDC_RX_PTR_OFS);
    wire wr_rx_cnt = wr && (AVS_ADDRESS_I == `PDC_RX_CNT_OFS);
    wire wr_tx_ptr = wr && (AVS_ADDRESS_I == `PDC_TX_PTR_OFS);
    wire wr_tx_cnt = wr && (AVS_ADDRESS_I == `PDC_TX_CNT_OFS);
    wire wr_rx_nptr = wr && (AVS_ADDRESS_I == `PDC_RX_NPTR_OFS);
    wire wr_rx_ncnt = wr && (AVS_ADDRESS_I == `PDC_RX_NCNT_OFS);
    wire wr_tx_nptr = wr && (AVS_ADDRESS_I == `PDC_TX_NPTR_OFS);
    wire wr_tx_ncnt = wr && (AVS_ADDRESS_I == `PDC_TX_NCNT_OFS);
    wire wr_ctrl = wr && (AVS_ADDRESS_I == `PDC_CTRL_OFS);
    wire wr_size = wr && (AVS_ADDRESS_I == `PDC_SIZE_OFS);

    // Channels stall on zero count even while enabled
    wire rx_ready = rx_en_reg && (rx_cnt_reg != 16'h0000);
    wire tx_ready = tx_en_reg && (tx_cnt_reg != 16'h0000);

    wire [31:0] step = (size_reg == `PDC_SIZE_WORD) ? 32'h4 :
        (size_reg == `PDC_SIZE_HALF) ? 32'h2 : 32'h1;

    // Pending requests: a new rising request is latched, and the lowest-numbered
    // pending peripheral goes first; only one is served at a time.
    reg [NPER-1:0] rx_pick, tx_pick;
    integer k;
    always @* begin
        rx_pick = {NPER{1'b0}};
        tx_pick = {NPER{1'b0}};
        for (k = NPER - 1; k >= 0; k = k - 1) begin
            if (rx_pend_reg[k]) begin
                rx_pick = {NPER{1'b0}};
                rx_pick[k] = 1'b1;
            end
            if (tx_pend_reg[k]) begin
                tx_pick = {NPER{1'b0}};
                tx_pick[k] = 1'b1;
            end
        end
    end
    wire rx_any = rx_ready && (rx_pend_reg != {NPER{1'b0}});
    wire tx_any = tx_ready && (tx_pend_reg != {NPER{1'b0}});

    wire start = (state_reg == ST_IDLE) && (rx_any || tx_any);
    wire done = (state_reg == ST_DONE);
    wire done_rx = done && !dir_tx_reg;
    wire done_tx = done && dir_tx_reg;

    // Set wins over the serve-clear of a pending request
    genvar g;
    generate
        for (g = 0; g < NPER; g = g + 1) begin : g_pend
            always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
                if (!RESET_N_I) begin
                    rx_pend_reg[g] <= 1'b0;
                    tx_pend_reg[g] <= 1'b0;
                    rx_prev_reg[g] <= 1'b0;
                    tx_prev_reg[g] <= 1'b0;
                end else begin
                    rx_prev_reg[g] <= RX_REQ_I[g];
                    tx_prev_reg[g] <= TX_REQ_I[g];
                    if (RX_REQ_I[g] && !rx_prev_reg[g]) begin
                        rx_pend_reg[g] <= 1'b1;
                    end else if (done_rx && sel_reg[g]) begin
                        rx_pend_reg[g] <= 1'b0;
                    end
                    if (TX_REQ_I[g] && !tx_prev_reg[g]) begin
                        tx_pend_reg[g] <= 1'b1;
                    end else if (done_tx && sel_reg[g]) begin
                        tx_pend_reg[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Transfer sequencer
    always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_reg <= ST_IDLE;
            dir_tx_reg <= 1'b0;
            sel_reg <= {NPER{1'b0}};
            hold_reg <= 32'h0;
            BUS_REQ_O <= 1'b0;
            PER_RD_O <= {NPER{1'b0}};
            PER_WR_O <= {NPER{1'b0}};
            PER_WDATA_O <= 32'h0;
            MEM_ADDR_O <= 32'h0;
            MEM_RD_O <= 1'b0;
            MEM_WR_O <= 1'b0;
            MEM_SIZE_O <= `PDC_SIZE_RESET;
            MEM_WDATA_O <= 32'h0;
        end else begin
            PER_RD_O <= {NPER{1'b0}};
            PER_WR_O <= {NPER{1'b0}};
            MEM_RD_O <= 1'b0;
            MEM_WR_O <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        // Receive beats transmit on contention
                        dir_tx_reg <= !rx_any;
                        sel_reg <= rx_any ? rx_pick : tx_pick;
                        BUS_REQ_O <= 1'b1;
                        state_reg <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (BUS_GNT_I) begin
                        MEM_SIZE_O <= size_reg;
                        if (dir_tx_reg) begin
                            // Single bus cycle: read memory, write peripheral
                            MEM_ADDR_O <= tx_ptr_reg;
                            MEM_RD_O <= 1'b1;
                            PER_WR_O <= sel_reg;
                            PER_WDATA_O <= MEM_RDATA_I;
                            BUS_REQ_O <= 1'b0;
                            state_reg <= ST_DONE;
                        end else begin
                            PER_RD_O <= sel_reg;
                            hold_reg <= PER_RDATA_I;
                            state_reg <= ST_RXWR;
                        end
                    end
                end
                ST_RXWR: begin
                    MEM_ADDR_O <= rx_ptr_reg;
                    MEM_WDATA_O <= hold_reg;
                    MEM_WR_O <= 1'b1;
                    BUS_REQ_O <= 1'b0;
                    state_reg <= ST_DONE;
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Control and chaining; software writes override the pointer and count update
    wire rx_zero_next = done_rx && (rx_cnt_reg == 16'h0001);
    wire tx_zero_next = done_tx && (tx_cnt_reg == 16'h0001);
    always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rx_ptr_reg <= `PDC_PTR_RESET;
            rx_nptr_reg <= `PDC_PTR_RESET;
            tx_ptr_reg <= `PDC_PTR_RESET;
            tx_nptr_reg <= `PDC_PTR_RESET;
            rx_cnt_reg <= `PDC_CNT_RESET;
            rx_ncnt_reg <= `PDC_CNT_RESET;
            tx_cnt_reg <= `PDC_CNT_RESET;
            tx_ncnt_reg <= `PDC_CNT_RESET;
            rx_en_reg <= 1'b0;
            tx_en_reg <= 1'b0;
            rx_end_reg <= 1'b0;
            tx_end_reg <= 1'b0;
            size_reg <= `PDC_SIZE_RESET;
        end else begin
            if (done_rx) begin
                rx_ptr_reg <= rx_ptr_reg + step;
                rx_cnt_reg <= rx_cnt_reg - 16'h0001;
                if (rx_zero_next) begin
                    rx_end_reg <= 1'b1;
                    if (rx_ncnt_reg != 16'h0000) begin
                        rx_ptr_reg <= rx_nptr_reg;
                        rx_cnt_reg <= rx_ncnt_reg;
                        rx_ncnt_reg <= 16'h0000;
                    end
                end
            end
            if (done_tx) begin
                tx_ptr_reg <= tx_ptr_reg + step;
                tx_cnt_reg <= tx_cnt_reg - 16'h0001;
                if (tx_zero_next) begin
                    tx_end_reg <= 1'b1;
                    if (tx_ncnt_reg != 16'h0000) begin
                        tx_ptr_reg <= tx_nptr_reg;
                        tx_cnt_reg <= tx_ncnt_reg;
                        tx_ncnt_reg <= 16'h0000;
                    end
                end
            end
            // Completion in the same cycle keeps the flag set
            if ((wr_rx_cnt || wr_rx_ncnt) && !rx_zero_next) begin
                rx_end_reg <= 1'b0;
            end
            if ((wr_tx_cnt || wr_tx_ncnt) && !tx_zero_next) begin
                tx_end_reg <= 1'b0;
            end
            if (wr_rx_ptr) begin
                rx_ptr_reg <= (rx_ptr_reg & ~wmask) |
                    (AVS_WRITEDATA_I & wmask);
            end
            if (wr_tx_ptr) begin
                tx_ptr_reg <= (tx_ptr_reg & ~wmask) |
                    (AVS_WRITEDATA_I & wmask);
            end
            if (wr_rx_nptr) begin
                rx_nptr_reg <= (rx_nptr_reg & ~wmask) |
                    (AVS_WRITEDATA_I & wmask);
            end
            if (wr_tx_nptr) begin
                tx_nptr_reg <= (tx_nptr_reg & ~wmask) |
                    (AVS_WRITEDATA_I & wmask);
            end
            if (wr_rx_cnt) begin
                rx_cnt_reg <= (rx_cnt_reg & ~wmask[15:0]) |
                    (AVS_WRITEDATA_I[15:0] & wmask[15:0]);
            end
            if (wr_tx_cnt) begin
                tx_cnt_reg <= (tx_cnt_reg & ~wmask[15:0]) |
                    (AVS_WRITEDATA_I[15:0] & wmask[15:0]);
            end
            if (wr_rx_ncnt) begin
                rx_ncnt_reg <= (rx_ncnt_reg & ~wmask[15:0]) |
                    (AVS_WRITEDATA_I[15:0] & wmask[15:0]);
            end
            if (wr_tx_ncnt) begin
                tx_ncnt_reg <= (tx_ncnt_reg & ~wmask[15:0]) |
                    (AVS_WRITEDATA_I[15:0] & wmask[15:0]);
            end
            if (wr_size && AVS_BYTEENABLE_I[0]) begin
                size_reg <= AVS_WRITEDATA_I[1:0];
            end
            // Disable outranks enable in the same write
            if (wr_ctrl && AVS_BYTEENABLE_I[0]) begin
                if (AVS_WRITEDATA_I[`PDC_RX_DIS_BIT]) begin
                    rx_en_reg <= 1'b0;
                end else if (AVS_WRITEDATA_I[`PDC_RX_EN_BIT]) begin
                    rx_en_reg <= 1'b1;
                end
            end
            if (wr_ctrl && AVS_BYTEENABLE_I[1]) begin
                if (AVS_WRITEDATA_I[`PDC_TX_DIS_BIT]) begin
                    tx_en_reg <= 1'b0;
                end else if (AVS_WRITEDATA_I[`PDC_TX_EN_BIT]) begin
                    tx_en_reg <= 1'b1;
                end
            end
        end
    end

    // End flags registered; full and empty flags derived from the live counters
    assign RX_END_O = rx_end_reg;
    assign TX_END_O = tx_end_reg;
    assign RX_FULL_O = (rx_cnt_reg == 16'h0000) && (rx_ncnt_reg == 16'h0000);
    assign TX_EMPTY_O = (tx_cnt_reg == 16'h0000) && (tx_ncnt_reg == 16'h0000);

    // Read path; the control register is write-only and reads as zero
    always @* begin
        AVS_READDATA_O = 32'h0;
        if (AVS_READ_I && in_map) begin
            case (AVS_ADDRESS_I)
                `PDC_RX_PTR_OFS: AVS_READDATA_O = rx_ptr_reg;
                `PDC_RX_CNT_OFS: AVS_READDATA_O = {16'h0, rx_cnt_reg};
                `PDC_TX_PTR_OFS: AVS_READDATA_O = tx_ptr_reg;
                `PDC_TX_CNT_OFS: AVS_READDATA_O = {16'h0, tx_cnt_reg};
                `PDC_RX_NPTR_OFS: AVS_READDATA_O = rx_nptr_reg;
                `PDC_RX_NCNT_OFS: AVS_READDATA_O = {16'h0, rx_ncnt_reg};
                `PDC_TX_NPTR_OFS: AVS_READDATA_O = tx_nptr_reg;
                `PDC_TX_NCNT_OFS: AVS_READDATA_O = {16'h0, tx_ncnt_reg};
                `PDC_STAT_OFS: begin
                    AVS_READDATA_O[`PDC_RX_STAT_BIT] = rx_en_reg;
                    AVS_READDATA_O[`PDC_TX_STAT_BIT] = tx_en_reg;
                end
                `PDC_FLAG_OFS: AVS_READDATA_O = {28'h0, TX_EMPTY_O,
                    TX_END_O, RX_FULL_O, RX_END_O};
                `PDC_SIZE_OFS: AVS_READDATA_O = {30'h0, size_reg};
                default: AVS_READDATA_O = 32'h0;
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: hdl/pdc_defines.vh */
// Register map, field positions and reset values of the peripheral DMA
// channel pair. Definitions only; included by the channel-pair module.
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH
`define PDC_RX_PTR_OFS 12'h100
`define PDC_RX_CNT_OFS 12'h104
`define PDC_TX_PTR_OFS 12'h108
`define PDC_TX_CNT_OFS 12'h10c
`define PDC_RX_NPTR_OFS 12'h110
`define PDC_RX_NCNT_OFS 12'h114
`define PDC_TX_NPTR_OFS 12'h118
`define PDC_TX_NCNT_OFS 12'h11c
`define PDC_CTRL_OFS 12'h120
`define PDC_STAT_OFS 12'h124
`define PDC_FLAG_OFS 12'h128
`define PDC_SIZE_OFS 12'h12c
`define PDC_RX_EN_BIT 0
`define PDC_RX_DIS_BIT 1
`define PDC_TX_EN_BIT 8
`define PDC_TX_DIS_BIT 9
`define PDC_RX_STAT_BIT 0
`define PDC_TX_STAT_BIT 8
`define PDC_PTR_RESET 32'h0000_0000
`define PDC_CNT_RESET 16'h0000
`define PDC_SIZE_RESET 2'h0
`define PDC_SIZE_BYTE 2'h0
`define PDC_SIZE_HALF 2'h1
`define PDC_SIZE_WORD 2'h2
`endif

/* File: verification/pdc_monitor.sv */
// Checker for the peripheral DMA channel pair, top-level ports only.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pdc_monitor #(
    parameter NPER = 2
) (
    input wire logic SYS_CLK_I,              // Clock
    input wire logic RESET_N_I,              // Reset, active low
    input wire logic [11:0] AVS_ADDRESS_I,   // Register address
    input wire logic AVS_READ_I,             // Read strobe
    input wire logic AVS_WRITE_I,            // Write strobe
    input wire logic [31:0] AVS_WRITEDATA_I, // Write data
    input wire logic [3:0] AVS_BYTEENABLE_I, // Byte enables
    input wire logic [31:0] AVS_READDATA_O,  // Read data
    input wire logic [NPER-1:0] PER_RD_O,    // Holding reads
    input wire logic [NPER-1:0] PER_WR_O,    // Peripheral writes
    input wire logic BUS_REQ_O,              // Bus request
    input wire logic BUS_GNT_I,              // Bus grant
    input wire logic MEM_RD_O,               // Memory read
    input wire logic MEM_WR_O,               // Memory write
    input wire logic RX_END_O,               // Receive end flag
    input wire logic TX_END_O                // Transmit end flag
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    sequence rx_read_s; |PER_RD_O; endsequence
    sequence rx_store_s; MEM_WR_O && !MEM_RD_O; endsequence
    sequence rx_off_s;
        AVS_WRITE_I && AVS_ADDRESS_I == 12'h120 &&
        AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[1];
    endsequence
    sequence status_rd_s; AVS_READ_I && AVS_ADDRESS_I == 12'h124; endsequence
    rx_two_step_a:
        assert property (rx_read_s |=> rx_store_s)
        else $error("rx store late");
    tx_one_step_a:
        assert property (|PER_WR_O |-> MEM_RD_O && !MEM_WR_O)
        else $error("tx move not single cycle");
    rx_granted_a:
        assert property (rx_read_s |-> $past(BUS_GNT_I && BUS_REQ_O))
        else $error("rx read without grant");
    tx_granted_a:
        assert property (MEM_RD_O |-> $past(BUS_GNT_I && BUS_REQ_O))
        else $error("tx read without grant");
    one_move_a:
        assert property ($onehot0({PER_RD_O, PER_WR_O}) &&
            !(MEM_RD_O && MEM_WR_O))
        else $error("two moves at once");
    req_held_a:
        assert property (BUS_REQ_O && !BUS_GNT_I |=> BUS_REQ_O)
        else $error("request dropped before grant");
    disable_wins_a:
        assert property (rx_off_s ##2 status_rd_s |-> !AVS_READDATA_O[0])
        else $error("rx still enabled after disable");
    rx_end_clear_a:
        assert property (AVS_WRITE_I && AVS_BYTEENABLE_I[0] &&
            (AVS_ADDRESS_I & 12'hfef) == 12'h104 && !MEM_WR_O &&
            !(|PER_RD_O) && !$past(MEM_WR_O) |=> !RX_END_O)
        else $error("rx end flag not cleared");
    tx_end_clear_a:
        assert property (AVS_WRITE_I && AVS_BYTEENABLE_I[0] &&
            (AVS_ADDRESS_I & 12'hfef) == 12'h10c && !MEM_RD_O &&
            !$past(MEM_RD_O) |=> !TX_END_O)
        else $error("tx end flag not cleared");
    rx_end_cause_a:
        assert property ($rose(RX_END_O) |->
            $past(MEM_WR_O) || $past(MEM_WR_O, 2))
        else $error("rx end flag without transfer");
    tx_end_cause_a:
        assert property ($rose(TX_END_O) |->
            $past(MEM_RD_O) || $past(MEM_RD_O, 2))
        else $error("tx end flag without transfer");
endmodule
`default_nettype wire

/* File: verification/pdc_far_side.sv */
// Serial peripheral and zero-latency memory on the far side of the pair.
// Assumes a level grant and one holding register shared by the peripherals.
`timescale 1ns/1ps
`default_nettype none
module pdc_far_side (
    input wire logic clk_i,             // Clock
    input wire logic rst_n_i,           // Reset, active low
    input wire logic bus_req_i,         // Bus request
    input wire logic [1:0] per_rd_i,    // Holding register reads
    input wire logic [31:0] tx_addr_i,  // Address the next tx reads
    input wire logic [1:0] slow_i,      // Grant delay in cycles
    output logic bus_gnt_o,             // Bus grant
    output logic [31:0] per_rdata_o,    // Receive holding data
    output logic [31:0] mem_rdata_o     // Memory read data
);
    logic gnt_reg;
    logic [1:0] wait_reg;
    logic [15:0] cyc_reg;
    logic [31:0] hold_reg;
    // Grant never outlives the request, so a stale one cannot start a move
    assign bus_gnt_o = gnt_reg && bus_req_i;
    assign per_rdata_o = hold_reg;
    // Idle data toggles each cycle so a mistimed sample cannot match
    assign mem_rdata_o = bus_req_i ? {~tx_addr_i[15:0], tx_addr_i[15:0]}
        : {cyc_reg, ~cyc_reg};
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gnt_reg <= 1'b0;
            wait_reg <= 2'h0;
            cyc_reg <= 16'h0;
            hold_reg <= 32'h5a00_0000;
        end else begin
            cyc_reg <= cyc_reg + 16'h1;
            if (|per_rd_i)
                hold_reg <= hold_reg + 32'h1;
            if (!bus_req_i) begin
                gnt_reg <= 1'b0;
                wait_reg <= 2'h0;
            end else if (wait_reg >= slow_i)
                gnt_reg <= 1'b1;
            else
                wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule
`default_nettype wire

/* File: verification/pdc_channel_pair_tb.sv */
// Self-checking bench for the peripheral DMA channel pair.
// Assumes the far-side model beside the design and a zero-wait register port.
`timescale 1ns/1ps
`default_nettype none
module pdc_channel_pair_tb;
    typedef struct {
        logic [31:0] addr;
        logic [31:0] data;
        logic [1:0] size;
        logic [1:0] sel;
        logic is_tx;
    } pdc_exp_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] addr = 12'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [1:0] rx_req = 2'h0;
    logic [1:0] tx_req = 2'h0;
    logic [1:0] slow = 2'h0;
    logic [31:0] tx_hint = 32'h0;
    wire [31:0] rdata, per_rdata, mem_rdata, per_wdata, mem_addr, mem_wdata;
    wire waitreq, gnt, bus_req, mem_rd, mem_wr, rx_end, rx_full;
    wire tx_end, tx_empty;
    wire [1:0] per_rd, per_wr, mem_size;
    pdc_exp_t exp_q[$];
    pdc_exp_t e;
    int failures = 0;
    int total_checks = 0;
    logic [31:0] rx_ptr, tx_ptr, nptr, v;
    logic [31:0] hold = 32'h5a00_0000;
    logic [15:0] rx_cnt, tx_cnt;
    logic [1:0] size = 2'h0;
    logic [1:0] last_sel = 2'h0;
    logic [31:0] ctl [6] = '{32'h1, 32'h0, 32'h3, 32'h100, 32'h300, 32'h101};
    logic [31:0] sts [6] = '{32'h1, 32'h1, 32'h0, 32'h100, 32'h0, 32'h101};
    always #5 clk = ~clk;
    pdc_channel_pair #(.NPER(2)) dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
        .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
        .RX_REQ_I(rx_req), .TX_REQ_I(tx_req), .PER_RD_O(per_rd),
        .PER_WR_O(per_wr), .PER_RDATA_I(per_rdata), .PER_WDATA_O(per_wdata),
        .BUS_REQ_O(bus_req), .BUS_GNT_I(gnt), .MEM_ADDR_O(mem_addr),
        .MEM_RD_O(mem_rd), .MEM_WR_O(mem_wr), .MEM_SIZE_O(mem_size),
        .MEM_WDATA_O(mem_wdata), .MEM_RDATA_I(mem_rdata), .RX_END_O(rx_end),
        .RX_FULL_O(rx_full), .TX_END_O(tx_end), .TX_EMPTY_O(tx_empty));
    pdc_far_side far (.clk_i(clk), .rst_n_i(rst_n), .bus_req_i(bus_req),
        .per_rd_i(per_rd), .tx_addr_i(tx_hint), .slow_i(slow),
        .bus_gnt_o(gnt), .per_rdata_o(per_rdata), .mem_rdata_o(mem_rdata));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        @(posedge clk);
        while (waitreq !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk);
        end
        v = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n == 50) begin
            chk(32'h1, 32'h0);
            end_of_test();
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] want);
        bus(1'b0, a, 32'h0);
        chk(v, want);
    endtask
    task automatic settle();
        int n = 0;
        repeat (2) @(posedge clk);
        while ((exp_q.size() != 0 || bus_req !== 1'b0) && n < 200) begin
            n++;
            @(posedge clk);
        end
        if (n == 200) begin
            chk(32'h1, 32'h0);
            end_of_test();
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic fire(input logic [1:0] r, input logic [1:0] t);
        @(posedge clk);
        rx_req <= r;
        tx_req <= t;
        slow <= 2'($urandom);
        repeat (2) @(posedge clk);
        rx_req <= 2'h0;
        tx_req <= 2'h0;
        settle();
    endtask
    task automatic rx_move(input int i);
        exp_q.push_back('{rx_ptr, hold, size, 2'(1 << i), 1'b0});
        hold++;
        rx_ptr += 32'h1 << size;
        rx_cnt--;
    endtask
    task automatic tx_move(input int i);
        exp_q.push_back('{tx_ptr, {~tx_ptr[15:0], tx_ptr[15:0]}, size,
            2'(1 << i), 1'b1});
        tx_hint <= tx_ptr;
        tx_ptr += 32'h1 << size;
        tx_cnt--;
    endtask
    always @(posedge clk) begin
        if ((|per_rd) === 1'b1)
            last_sel <= per_rd;
        if (mem_wr === 1'b1 || (|per_wr) === 1'b1) begin
            if (exp_q.size() == 0)
                chk(32'h1, 32'h0);
            else begin
                e = exp_q.pop_front();
                chk(mem_addr, e.addr);
                chk(mem_size, e.size);
                if (e.is_tx) begin
                    chk(per_wdata, e.data);
                    chk(per_wr, e.sel);
                end else begin
                    chk(mem_wdata, e.data);
                    chk(last_sel, e.sel);
                end
            end
        end
    end
    initial begin
        void'($urandom(32'hdb8e9e4a));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 'h100; a < 'h128; a += 4)
            rchk(12'(a), 32'h0);
        rchk(12'h130, 32'h0);
        chk(rx_full, 32'h1);
        chk(tx_empty, 32'h1);
        bus(1'b1, 12'h104, 32'hffff_ffff);
        rchk(12'h104, 32'h0000_ffff);
        $display("test reset_map done");
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 12'h120, ctl[i]);
            rchk(12'h124, sts[i]);
        end
        $display("test control done");
        for (int s = 0; s < 3; s++) begin
            size = 2'(s);
            rx_ptr = $urandom & 32'h0fff_fff0;
            rx_cnt = 16'h2;
            bus(1'b1, 12'h12c, {30'h0, size});
            bus(1'b1, 12'h100, rx_ptr);
            bus(1'b1, 12'h104, 32'h2);
            repeat (2) begin
                rx_move(s % 2);
                fire(2'(1 << (s % 2)), 2'h0);
                rchk(12'h100, rx_ptr);
                rchk(12'h104, {16'h0, rx_cnt});
            end
            chk(rx_end, 32'h1);
            chk(rx_full, 32'h1);
        end
        $display("test rx_sizes done");
        fire(2'h1, 2'h0);
        rx_move(0);
        bus(1'b1, 12'h104, 32'h3);
        @(posedge clk);
        chk(rx_end, 32'h0);
        rx_cnt = 16'h2;
        settle();
        rchk(12'h104, 32'h2);
        rx_ptr = $urandom & 32'h0fff_fffc;
        nptr = $urandom & 32'h0fff_fffc;
        bus(1'b1, 12'h100, rx_ptr);
        bus(1'b1, 12'h104, 32'h1);
        bus(1'b1, 12'h110, nptr);
        bus(1'b1, 12'h114, 32'h3);
        rx_move(1);
        fire(2'h2, 2'h0);
        rchk(12'h100, nptr);
        rchk(12'h104, 32'h3);
        rchk(12'h114, 32'h0);
        chk(rx_full, 32'h0);
        rx_ptr = nptr;
        rx_cnt = 16'h3;
        $display("test rx_chain done");
        tx_ptr = $urandom & 32'h0fff_fffc;
        tx_cnt = 16'h2;
        bus(1'b1, 12'h108, tx_ptr);
        bus(1'b1, 12'h10c, 32'h2);
        repeat (2) begin
            tx_move(1);
            fire(2'h0, 2'h2);
            rchk(12'h108, tx_ptr);
        end
        chk(tx_end, 32'h1);
        chk(tx_empty, 32'h1);
        bus(1'b1, 12'h11c, 32'h1);
        @(posedge clk);
        chk(tx_end, 32'h0);
        chk(tx_empty, 32'h0);
        $display("test tx done");
        bus(1'b1, 12'h10c, 32'h1);
        tx_cnt = 16'h1;
        rx_move(0);
        rx_move(1);
        tx_move(0);
        fire(2'h3, 2'h1);
        rchk(12'h104, {16'h0, rx_cnt});
        $display("test priority done");
        end_of_test();
    end
endmodule
bind pdc_channel_pair pdc_monitor #(.NPER(NPER)) u_mon (
    .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
    .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
    .PER_RD_O(PER_RD_O), .PER_WR_O(PER_WR_O), .BUS_REQ_O(BUS_REQ_O),
    .BUS_GNT_I(BUS_GNT_I), .MEM_RD_O(MEM_RD_O), .MEM_WR_O(MEM_WR_O),
    .RX_END_O(RX_END_O), .TX_END_O(TX_END_O));
`default_nettype wire
